// File: gkd_pkg.sv
// constants shared by the ground key detector
package gkd_pkg;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS = 10;
	// debounce step and filter sample period, 1.25 ms
	localparam int TICK_PERIOD_NS = 1250000;
	localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int TICK_W = 17;

	// ****************************************************************
	// register bus
	// ****************************************************************
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam logic [7:0] ADDR_IRQ_PEND = 8'h00;
	localparam logic [7:0] ADDR_IRQ_EN = 8'h01;
	localparam logic [7:0] ADDR_LINE_CTRL = 8'h02;
	localparam logic [7:0] ADDR_LOOP_STAT = 8'h03;
	localparam logic [7:0] ADDR_DEBOUNCE = 8'h04;
	localparam logic [7:0] ADDR_LONG_CUR = 8'h05;
	localparam logic [7:0] ADDR_ASSERT_THR = 8'h06;
	localparam logic [7:0] ADDR_RELEASE_THR = 8'h07;
	localparam logic [7:0] ADDR_FILTER_COEF = 8'h08;
	localparam logic [7:0] ADDR_OFFHOOK_THR = 8'h09;
	localparam logic [7:0] ADDR_ONHOOK_THR = 8'h0A;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int GK_IRQ_BIT = 0;
	localparam int LCR_BIT = 0;
	localparam int GK_STATUS_BIT = 1;
	localparam int LF_LSB = 0;
	localparam int LFS_LSB = 4;

	// ****************************************************************
	// line drive state codes
	// ****************************************************************
	localparam logic [2:0] LS_OPEN = 3'h0;
	localparam logic [2:0] LS_FWD_ACTIVE = 3'h1;
	localparam logic [2:0] LS_TIP_OPEN = 3'h3;
	localparam logic [2:0] LS_REV_ACTIVE = 3'h5;
	localparam logic [2:0] LS_RING_OPEN = 3'h7;

	// ****************************************************************
	// limits, 3.097 uA per code
	// ****************************************************************
	localparam logic [15:0] GK_THR_MAX = 16'h142E;
	localparam logic [15:0] LCR_THR_MAX = 16'h4CF0;
	localparam int COEF_SHIFT = 14;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [15:0] RST_COEF = 16'h0A10;
	localparam logic [15:0] RST_ASSERT_THR = 16'h08D4;
	localparam logic [15:0] RST_RELEASE_THR = 16'h064E;
	localparam logic [15:0] RST_OFFHOOK_THR = 16'h11A8;
	localparam logic [15:0] RST_ONHOOK_THR = 16'h0C9C;
	localparam logic [15:0] RST_DEBOUNCE = 16'h0008;

endpackage : gkd_pkg

// File: gkd_top.sv
// ground key detector: longitudinal current, filter, hysteresis, debounce
//
// Functional notes
// [R1] long current is produced only in tip-open or ring-open shadow state
// [R2] long current is half of q1 plus q2 minus q5 minus q6
// [R3] long current goes through a low-pass filter before comparison
// [R4] filter coefficient zero blocks, 4000h passes unfiltered
// [R5] software computes the coefficient from the cutoff frequency
// [R6] software should program coefficient 0A10h
// [R7] filtered current is compared against the assert threshold
// [R8] a lower release threshold gives hysteresis
// [R9] debounced status changes only after full interval of opposite input
// [R10] debounce interval is 16 bits of 1.25 ms steps
// [R11] satisfied assert interval sets ground key status
// [R12] loop closure rising, not ground key, moves open state to active
// [R13] auto transition relies on the loop-closure bit
// [R14] shadow reads 3 in tip-open, 1 in forward-active after closure
// [R15] ground key pending flag and enable bit exist
// [R16] three-bit shadow field is read-only, shows the drive state
// [R17] both thresholds are 16-bit values of 3.097 uA steps
// [R18] a threshold above 16 mA disables ground key detection
// [R19] ground key status is read-only debounced output
// [R20] long current value is a 16-bit read-only monitor
// [R21] loop threshold above 61 mA disables loop closure detection
// [R22] each status change sets pending; interrupt only when enabled
// [R23] status clears after release condition lasts the full interval
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ns
module gkd_top #(
	parameter int TICK_COUNT = gkd_pkg::TICK_CYCLES
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// register port
	input wire logic [gkd_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [gkd_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [gkd_pkg::DATA_W-1:0] reg_rdata,
	// sensed linefeed transistor currents
	input wire logic signed [15:0] sense_q1,
	input wire logic signed [15:0] sense_q2,
	input wire logic signed [15:0] sense_q5,
	input wire logic signed [15:0] sense_q6,
	// loop-closure detector
	input wire logic loop_closure_in,
	output logic [15:0] offhook_current_threshold,
	output logic [15:0] onhook_current_threshold,
	// status
	output logic ground_key_status,
	output logic [2:0] line_state_shadow,
	output logic [15:0] long_current_value,
	output logic gk_irq
);
	import gkd_pkg::*;

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic [TICK_W-1:0] tick_cnt;
		logic tick;
		logic [15:0] long_cur;
		logic signed [15:0] filt;
		logic comp;
		logic status;
		logic [15:0] db_cnt;
		logic pending;
		logic enable;
		logic [2:0] lf_req;
		logic [2:0] lf_shadow;
		logic loop_closure_flag;
		logic lcr_prev;
		logic [15:0] dbi;
		logic [15:0] hith;
		logic [15:0] loth;
		logic [15:0] coef;
		logic [15:0] offhk;
		logic [15:0] onhk;
		logic [15:0] rdata;
	} gkd_state_s;

	localparam gkd_state_s ST_RESET = '{
		lf_req: LS_OPEN,
		lf_shadow: LS_OPEN,
		dbi: RST_DEBOUNCE,
		hith: RST_ASSERT_THR,
		loth: RST_RELEASE_THR,
		coef: RST_COEF,
		offhk: RST_OFFHOOK_THR,
		onhk: RST_ONHOOK_THR,
		default: '0
	};

	gkd_state_s st;
	gkd_state_s next_st;
	logic [1:0] rst_sync;
	logic rst_q_n;

	// ****************************************************************
	// reset release
	// ****************************************************************
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_q_n = rst_sync[1];

	// ****************************************************************
	// datapath
	// ****************************************************************
	logic signed [17:0] sum;
	logic signed [17:0] half;
	logic [15:0] sat;
	logic signed [16:0] diff;
	logic signed [33:0] prod;
	logic signed [16:0] step;
	logic [16:0] mag;
	logic gk_disabled;
	logic lcr_enabled;
	logic in_open;
	logic [16:0] db_inc;
	logic wr_pend;
	logic status_set;

	always_comb begin
		next_st = st;
		next_st.rdata = 16'h0000;
		// 1.25 ms enable pulse
		next_st.tick = 1'b0;
		if (st.tick_cnt == TICK_W'(TICK_COUNT - 1)) begin
			next_st.tick_cnt = '0;
			next_st.tick = 1'b1;
		end else begin
			next_st.tick_cnt = st.tick_cnt + TICK_W'(1);
		end

		in_open = (st.lf_shadow == LS_TIP_OPEN) ||
			(st.lf_shadow == LS_RING_OPEN);
		sum = 18'(sense_q1) + 18'(sense_q2) - 18'(sense_q5)
			- 18'(sense_q6); // R2
		half = sum >>> 1; // R2
		if (half > 18'sd32767) begin
			sat = 16'h7FFF;
		end else if (half < -18'sd32768) begin
			sat = 16'h8000;
		end else begin
			sat = half[15:0];
		end

		// first-order filter: y += (x - y) * coef / 4000h
		diff = 17'($signed(st.long_cur)) - 17'(st.filt);
		prod = 34'(diff) * 34'($signed({1'b0, st.coef})); // R4
		step = 17'(prod >>> COEF_SHIFT);
		if (st.tick) begin
			next_st.long_cur = in_open ? sat : 16'h0000; // R1
			next_st.filt = 16'(17'(st.filt) + step); // R3
		end

		// magnitude compare with hysteresis
		mag = st.filt[15] ? 17'(-17'(st.filt)) : 17'(st.filt);
		gk_disabled = (st.hith > GK_THR_MAX) ||
			(st.loth > GK_THR_MAX); // R18
		if (gk_disabled) begin
			next_st.comp = 1'b0; // R18
		end else if (!st.comp && mag >= 17'(st.hith)) begin
			next_st.comp = 1'b1; // R7
		end else if (st.comp && mag < 17'(st.loth)) begin
			next_st.comp = 1'b0; // R8
		end

		// debounce, counted in 1.25 ms steps
		status_set = 1'b0;
		db_inc = 17'(st.db_cnt) + 17'h0_0001;
		if (st.tick) begin
			if (st.comp == st.status) begin
				next_st.db_cnt = 16'h0000; // R9
			end else if (db_inc >= 17'(st.dbi)) begin // R10
				next_st.status = st.comp; // R11 R23
				next_st.db_cnt = 16'h0000;
				status_set = 1'b1; // R22
			end else begin
				next_st.db_cnt = db_inc[15:0]; // R9
			end
		end

		// loop closure gating and automatic line transition
		lcr_enabled = (st.offhk <= LCR_THR_MAX) &&
			(st.onhk <= LCR_THR_MAX); // R21
		next_st.loop_closure_flag = loop_closure_in & lcr_enabled; // R13 R21
		next_st.lcr_prev = st.loop_closure_flag;
		if (st.loop_closure_flag && !st.lcr_prev) begin // R12
			if (st.lf_shadow == LS_TIP_OPEN) begin
				next_st.lf_shadow = LS_FWD_ACTIVE; // R14
			end else if (st.lf_shadow == LS_RING_OPEN) begin
				next_st.lf_shadow = LS_REV_ACTIVE; // R12
			end
		end

		// register writes
		wr_pend = reg_wr && (reg_addr == ADDR_IRQ_PEND) &&
			reg_wdata[GK_IRQ_BIT];
		next_st.pending = (st.pending & ~wr_pend) | status_set; // R22
		if (reg_wr) begin
			case (reg_addr)
				ADDR_IRQ_EN: begin
					next_st.enable = reg_wdata[GK_IRQ_BIT]; // R15
				end
				ADDR_LINE_CTRL: begin
					next_st.lf_req = reg_wdata[LF_LSB +: 3];
					next_st.lf_shadow = reg_wdata[LF_LSB +: 3];
				end
				ADDR_DEBOUNCE: begin
					next_st.dbi = reg_wdata; // R10
				end
				ADDR_ASSERT_THR: begin
					next_st.hith = reg_wdata; // R17
				end
				ADDR_RELEASE_THR: begin
					next_st.loth = reg_wdata; // R17
				end
				ADDR_FILTER_COEF: begin
					next_st.coef = reg_wdata; // R4
				end
				ADDR_OFFHOOK_THR: begin
					next_st.offhk = reg_wdata;
				end
				ADDR_ONHOOK_THR: begin
					next_st.onhk = reg_wdata;
				end
				default: begin
				end
			endcase
		end

		// register reads, answered in the next cycle
		if (reg_rd) begin
			case (reg_addr)
				ADDR_IRQ_PEND: begin
					next_st.rdata[GK_IRQ_BIT] = st.pending; // R15
				end
				ADDR_IRQ_EN: begin
					next_st.rdata[GK_IRQ_BIT] = st.enable;
				end
				ADDR_LINE_CTRL: begin
					next_st.rdata[LF_LSB +: 3] = st.lf_req;
					next_st.rdata[LFS_LSB +: 3] = st.lf_shadow; // R16
				end
				ADDR_LOOP_STAT: begin
					next_st.rdata[LCR_BIT] = st.loop_closure_flag;
					next_st.rdata[GK_STATUS_BIT] = st.status; // R19
				end
				ADDR_DEBOUNCE: begin
					next_st.rdata = st.dbi;
				end
				ADDR_LONG_CUR: begin
					next_st.rdata = st.long_cur; // R20
				end
				ADDR_ASSERT_THR: begin
					next_st.rdata = st.hith;
				end
				ADDR_RELEASE_THR: begin
					next_st.rdata = st.loth;
				end
				ADDR_FILTER_COEF: begin
					next_st.rdata = st.coef;
				end
				ADDR_OFFHOOK_THR: begin
					next_st.rdata = st.offhk;
				end
				ADDR_ONHOOK_THR: begin
					next_st.rdata = st.onhk;
				end
				default: begin
					next_st.rdata = 16'h0000;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_q_n) begin
		if (!rst_q_n) begin
			st <= ST_RESET;
		end else begin
			st <= next_st;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign reg_rdata = st.rdata;
	assign offhook_current_threshold = st.offhk;
	assign onhook_current_threshold = st.onhk;
	assign ground_key_status = st.status;
	assign line_state_shadow = st.lf_shadow;
	assign long_current_value = st.long_cur;
	assign gk_irq = st.pending & st.enable; // R22

endmodule : gkd_top

// File: gkd_chk.sv
// port assertions for the ground key detector
`timescale 1ns/1ns
module gkd_chk #(
	parameter int TICK_COUNT = gkd_pkg::TICK_CYCLES
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// register port
	input wire logic [gkd_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [gkd_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [gkd_pkg::DATA_W-1:0] reg_rdata,
	// detector
	input wire logic loop_closure_in,
	input wire logic [15:0] offhook_current_threshold,
	input wire logic [15:0] onhook_current_threshold,
	input wire logic ground_key_status,
	input wire logic [2:0] line_state_shadow,
	input wire logic [15:0] long_current_value,
	input wire logic gk_irq
);
	import gkd_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	int closed_cnt;
	// cycles spent outside tip-open and ring-open
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			closed_cnt <= 0;
		else if (line_state_shadow inside {LS_TIP_OPEN, LS_RING_OPEN})
			closed_cnt <= 0;
		else if (closed_cnt <= TICK_COUNT + 1)
			closed_cnt <= closed_cnt + 1;
	end
	sequence s_lcr_rise;
		$rose(loop_closure_in) && line_state_shadow == LS_TIP_OPEN &&
			offhook_current_threshold <= LCR_THR_MAX &&
			onhook_current_threshold <= LCR_THR_MAX;
	endsequence
	sequence s_no_write;
		!reg_wr [*5];
	endsequence
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
		else $error("read data not idle");
	a_read_long: assert property (reg_rd && reg_addr == ADDR_LONG_CUR
		|=> reg_rdata == $past(long_current_value))
		else $error("long current read wrong");
	a_read_status: assert property (reg_rd && reg_addr == ADDR_LOOP_STAT
		|=> reg_rdata[GK_STATUS_BIT] == $past(ground_key_status))
		else $error("status read wrong");
	a_shadow_write: assert property (reg_wr && reg_addr == ADDR_LINE_CTRL
		|=> line_state_shadow == 3'($past(reg_wdata)))
		else $error("line state write lost");
	a_shadow_auto: assert property (s_lcr_rise ##0 s_no_write
		|-> line_state_shadow == LS_FWD_ACTIVE)
		else $error("no automatic transition");
	a_long_closed: assert property (closed_cnt > TICK_COUNT + 1
		|-> long_current_value == '0)
		else $error("long current outside open states");
	a_status_steady: assert property ($changed(ground_key_status)
		|=> $stable(ground_key_status) [*3])
		else $error("status changed too soon");
	a_irq_cause: assert property ($rose(gk_irq)
		|-> $changed(ground_key_status) || $past(reg_wr))
		else $error("interrupt without cause");
endmodule : gkd_chk
bind gkd_top gkd_chk #(.TICK_COUNT(TICK_COUNT)) chk_u (.sys_clk, .rst_n,
	.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .loop_closure_in,
	.offhook_current_threshold, .onhook_current_threshold,
	.ground_key_status, .line_state_shadow, .long_current_value, .gk_irq);

// File: gkd_loop_sim.sv
// subscriber loop seen through the linefeed transistor current senses
`timescale 1ns/1ns
module gkd_loop_sim (
	// loop condition
	input wire logic signed [15:0] long_amp,
	input wire logic signed [15:0] loop_base,
	input wire logic close_loop,
	// sensed currents and loop closure
	output logic signed [15:0] sense_q1,
	output logic signed [15:0] sense_q2,
	output logic signed [15:0] sense_q5,
	output logic signed [15:0] sense_q6,
	output logic loop_closure_in
);
	// metallic current cancels, longitudinal part appears twice
	assign sense_q1 = loop_base + long_amp;
	assign sense_q2 = long_amp;
	assign sense_q5 = loop_base;
	assign sense_q6 = 16'sh0000;
	assign loop_closure_in = close_loop;
endmodule : gkd_loop_sim

// File: tb_top.sv
// self-checking bench for the ground key detector
`timescale 1ns/1ns
module tb_top;
	import gkd_pkg::*;
	localparam int TICKS = 4;
	logic sys_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic close_loop = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, long_current_value;
	logic signed [15:0] long_amp = 16'sh0000, loop_base = 16'sh0000, amp;
	logic signed [15:0] sense_q1, sense_q2, sense_q5, sense_q6;
	logic [2:0] line_state_shadow;
	logic loop_closure_in, ground_key_status, gk_irq;
	logic [15:0] offhook_current_threshold, onhook_current_threshold;
	int miscompares = 0, samples_checked = 0, cycles = 0;
	logic [15:0] rv [11] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
		16'h0008, 16'h0000, 16'h08d4, 16'h064e, 16'h0a10, 16'h11a8, 16'h0c9c};
	gkd_loop_sim loop_u (.long_amp, .loop_base, .close_loop, .sense_q1,
		.sense_q2, .sense_q5, .sense_q6, .loop_closure_in);
	gkd_top #(.TICK_COUNT(TICKS)) dut_u (.sys_clk, .rst_n, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sense_q1, .sense_q2,
		.sense_q5, .sense_q6, .loop_closure_in,
		.offhook_current_threshold, .onhook_current_threshold,
		.ground_key_status, .line_state_shadow, .long_current_value, .gk_irq);
	initial begin
		forever #5 sys_clk = ~sys_clk;
	end
	function automatic logic [15:0] exp_long(input logic signed [15:0] a,
		input logic signed [15:0] b, c, d);
		logic signed [17:0] s;
		s = a + b - c - d;
		return s[16:1];
	endfunction : exp_long
	// host side coefficient for a cutoff frequency in Hz
	function automatic logic [15:0] coef_of(input int f);
		return 16'($rtoi($ceil(2.0 * 3.14159265 * f * 4096.0 / 800.0)) * 8);
	endfunction : coef_of
	task automatic chk(input logic [15:0] seen, input logic [15:0] want);
		samples_checked++;
		if (seen !== want) begin
			miscompares++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, want);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [15:0] want);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, want);
	endtask : rdc
	task automatic wait_st(input logic v);
		int n;
		n = 0;
		while (ground_key_status !== v && n < 200) begin
			@(posedge sys_clk);
			#1 n++;
		end
		chk(16'(ground_key_status), 16'(v));
	endtask : wait_st
	task automatic final_report;
		$display("checked %0d mismatched %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : final_report
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			final_report();
		end
	end
	initial begin
		void'($urandom(32'h0000_e488));
		repeat (20) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		for (int i = 0; i < 12; i++)
			rdc(8'(i), (i < 11) ? rv[i] : 16'h0000);
		wr(8'h05, 16'hffff);
		wr(8'h03, 16'hffff);
		rdc(8'h05, 16'h0000);
		rdc(8'h03, 16'h0000);
		wr(8'h08, coef_of(10));
		rdc(8'h08, 16'h0a10);
		wr(8'h08, 16'h4000);
		wr(8'h04, 16'h0002);
		wr(8'h01, 16'h0001);
		wr(8'h02, 16'h0003);
		chk(16'(line_state_shadow), 16'h0003);
		amp = 16'h0960 + 16'($urandom % 3000);
		if ($urandom % 2)
			amp = -amp;
		loop_base <= 16'($urandom % 1000);
		long_amp <= amp;
		repeat (8) @(posedge sys_clk);
		chk(16'(ground_key_status), 16'h0000);
		wait_st(1'b1);
		chk(long_current_value, exp_long(sense_q1, sense_q2, sense_q5, sense_q6));
		rdc(8'h03, 16'h0002);
		chk(16'(gk_irq), 16'h0001);
		rdc(8'h00, 16'h0001);
		wr(8'h00, 16'h0001);
		chk(16'(gk_irq), 16'h0000);
		@(posedge sys_clk) close_loop <= 1'b1;
		repeat (8) @(posedge sys_clk);
		#1 chk(16'(line_state_shadow), 16'h0001);
		wait_st(1'b0);
		rdc(8'h00, 16'h0001);
		wr(8'h01, 16'h0000);
		chk(16'(gk_irq), 16'h0000);
		@(posedge sys_clk) close_loop <= 1'b0;
		wr(8'h09, 16'h4cf1);
		chk(offhook_current_threshold, 16'h4cf1);
		chk(onhook_current_threshold, 16'h0c9c);
		wr(8'h02, 16'h0003);
		@(posedge sys_clk) close_loop <= 1'b1;
		repeat (8) @(posedge sys_clk);
		#1 chk(16'(line_state_shadow), 16'h0003);
		long_amp <= amp;
		wait_st(1'b1);
		chk(16'(line_state_shadow), 16'h0003);
		@(posedge sys_clk) close_loop <= 1'b0;
		wr(8'h09, 16'h11a8);
		@(posedge sys_clk) long_amp <= 16'sh0791;
		repeat (40) @(posedge sys_clk);
		#1 chk(16'(ground_key_status), 16'h0001);
		long_amp <= 16'sh03e8;
		wait_st(1'b0);
		wr(8'h08, 16'h0000);
		long_amp <= amp;
		repeat (40) @(posedge sys_clk);
		#1 chk(16'(ground_key_status), 16'h0000);
		wr(8'h06, 16'h142f);
		wr(8'h08, 16'h4000);
		repeat (40) @(posedge sys_clk);
		#1 chk(16'(ground_key_status), 16'h0000);
		wr(8'h06, 16'h08d4);
		wait_st(1'b1);
		wr(8'h02, 16'h0007);
		@(posedge sys_clk) close_loop <= 1'b1;
		repeat (8) @(posedge sys_clk);
		#1 chk(16'(line_state_shadow), 16'h0005);
		repeat (10) @(posedge sys_clk);
		#1 chk(long_current_value, 16'h0000);
		final_report();
	end
endmodule : tb_top
